// ===== design/iod_map.svh
`ifndef IOD_MAP_SVH
`define IOD_MAP_SVH

// I/O register offsets.
`define IOD_A_PORT0_DATA 8'h00
`define IOD_A_PORT1_DATA 8'h01
`define IOD_A_PORT2_DATA 8'h02
`define IOD_A_PORT3_DATA 8'h03
`define IOD_A_PORT0_IRQ_MASK 8'h04
`define IOD_A_PORT1_IRQ_MASK 8'h05
`define IOD_A_PORT2_IRQ_MASK 8'h06
`define IOD_A_PORT3_IRQ_MASK 8'h07
`define IOD_A_PIN_PORT_CONFIG 8'h08
`define IOD_A_TWO_WIRE_PIN_POSITION 8'h09
`define IOD_A_FUNCTION_A_ADDRESS 8'h10
`define IOD_A_A_EP0_BYTE_COUNT 8'h11
`define IOD_A_A_EP0_CONFIG 8'h12
`define IOD_A_A_EP1_BYTE_COUNT 8'h13
`define IOD_A_A_EP1_CONFIG 8'h14
`define IOD_A_A_EP2_BYTE_COUNT 8'h15
`define IOD_A_A_EP2_CONFIG 8'h16
`define IOD_A_UPSTREAM_TRAFFIC_CTRL 8'h1F
`define IOD_A_GLOBAL_IRQ_MASK 8'h20
`define IOD_A_ENDPOINT_IRQ_MASK 8'h21
`define IOD_A_PENDING_VECTOR 8'h23
`define IOD_A_TIMER_LOW_BYTE 8'h24
`define IOD_A_TIMER_HIGH_NIBBLE 8'h25
`define IOD_A_WATCHDOG_KICK 8'h26
`define IOD_A_TWO_WIRE_CTRL_STATUS 8'h28
`define IOD_A_TWO_WIRE_BYTE 8'h29

// Reset values.
`define IOD_RST_BYTE 8'h00
`define IOD_RST_NIBBLE 4'h0
`define IOD_RST_TIMER 12'h000

// Field positions of the timer.
`define IOD_TMR_HI_MSB 11
`define IOD_TMR_HI_LSB 8

// Timing: clock period and timer tick period in ns.
`define IOD_CLK_PERIOD_NS 10
`define IOD_TICK_PERIOD_NS 1000
`define IOD_TICK_CYCLES (`IOD_TICK_PERIOD_NS / `IOD_CLK_PERIOD_NS)

`endif

// ===== design/iod_pkg.sv
package iod_pkg;

   // I/O instruction kinds seen from the CPU core.
   typedef enum logic [1:0] {
      IOD_IO_READ_INSTR = 2'b00,
      IOD_IO_WRITE_DIRECT_INSTR = 2'b01,
      IOD_IO_WRITE_INDEXED_INSTR = 2'b10,
      IOD_IO_NO_INSTR = 2'b11
   } iod_op_t;

   // Access class of a decoded register.
   typedef enum logic [2:0] {
      IOD_ACC_NONE = 3'b000,
      IOD_ACC_RW = 3'b001,
      IOD_ACC_WO = 3'b010,
      IOD_ACC_RO = 3'b011,
      IOD_ACC_RC = 3'b100
   } iod_access_t;

endpackage : iod_pkg

// ===== design/iod_timer.sv
`timescale 1ns/1ns
`include "iod_map.svh"

module iod_timer (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic srst_i,
   // Low byte read strobe.
   input wire logic lo_rd_i,
   // Timer state.
   output logic [11:0] count_o,
   output logic [3:0] hi_latched_o
);
   import iod_pkg::*;

   logic [6:0] div;
   logic tick;

   // Divides the CPU clock down to one microsecond ticks.
   assign tick = (div == 7'(`IOD_TICK_CYCLES - 1));

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         div <= 7'h00;
      end else if (tick) begin
         div <= 7'h00;
      end else begin
         div <= div + 7'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         count_o <= `IOD_RST_TIMER;
      end else if (tick) begin
         count_o <= count_o + 12'h001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hi_latched_o <= `IOD_RST_NIBBLE;
      end else if (lo_rd_i) begin
         hi_latched_o <= count_o[`IOD_TMR_HI_MSB:`IOD_TMR_HI_LSB];
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   a_tick_period: assert property (tick |=> (!tick) [*8])
      else $error("timer ticks closer than the divider allows");
   a_count_step: assert property (!tick |=> $stable(count_o))
      else $error("timer moved without a tick");
   a_hi_latch: assert property (lo_rd_i |=> hi_latched_o == $past(count_o[11:8]))
      else $error("upper timer bits not latched on low read");
   a_hi_hold: assert property (!lo_rd_i |=> $stable(hi_latched_o))
      else $error("latched upper bits changed without a low read");

endmodule : iod_timer

// ===== design/iod_decode.sv
`timescale 1ns/1ns
`include "iod_map.svh"

// Operation
// - A read instruction returns the addressed register for the accumulator.
// - A direct write stores the accumulator at the instruction address.
// - An indexed write targets instruction address plus index register.
// - An indexed write with address zero targets the index value alone.
// - Pin interrupt masks sit at 0x04 to 0x07 and are write only.
// - Register 0x23 reads the pending vector and clears it.
// - Timer low byte at 0x24 is read only and counts at 1 MHz.
// - Timer upper four bits read only at 0x25.
// - Upstream traffic control at 0x1F is read and write.
// - Endpoint 0 to 2 count and config registers alternate from 0x11 to 0x16.
// - Reading the timer low byte latches the upper bits for later read.
module iod_decode (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic srst_i,
   // I/O instruction from the CPU core.
   input wire logic io_req_i,
   input wire iod_pkg::iod_op_t io_op_i,
   input wire logic [7:0] io_addr_i,
   input wire logic [7:0] index_x_i,
   input wire logic [7:0] acc_i,
   // Read answer to the accumulator.
   output logic rd_valid_o,
   output logic [7:0] rd_data_o,
   output logic unmapped_o,
   // Write strobe towards the peripherals.
   output logic wr_stb_o,
   output logic [7:0] wr_addr_o,
   output logic [7:0] wr_data_o,
   output logic watchdog_kick_o,
   // Interrupt controller link.
   input wire logic [7:0] vector_i,
   output logic vector_clr_o
);
   import iod_pkg::*;

   // Returns the access class of an I/O address.
   function automatic iod_access_t iod_access(input logic [7:0] a);
      if (a <= `IOD_A_PORT3_DATA) begin
         return IOD_ACC_RW;
      end else if (a <= `IOD_A_PORT3_IRQ_MASK) begin
         return IOD_ACC_WO;
      end else if (a <= `IOD_A_TWO_WIRE_PIN_POSITION) begin
         return IOD_ACC_RW;
      end else if (a < `IOD_A_FUNCTION_A_ADDRESS) begin
         return IOD_ACC_NONE;
      end else if (a <= `IOD_A_A_EP2_CONFIG) begin
         return IOD_ACC_RW;
      end else if (a < `IOD_A_UPSTREAM_TRAFFIC_CTRL) begin
         return IOD_ACC_NONE;
      end else if (a <= `IOD_A_ENDPOINT_IRQ_MASK) begin
         return IOD_ACC_RW;
      end else if (a == `IOD_A_PENDING_VECTOR) begin
         return IOD_ACC_RC;
      end else if (a == `IOD_A_TIMER_LOW_BYTE) begin
         return IOD_ACC_RO;
      end else if (a == `IOD_A_TIMER_HIGH_NIBBLE) begin
         return IOD_ACC_RO;
      end else if (a == `IOD_A_WATCHDOG_KICK) begin
         return IOD_ACC_WO;
      end else if (a == `IOD_A_TWO_WIRE_CTRL_STATUS) begin
         return IOD_ACC_RW;
      end else if (a == `IOD_A_TWO_WIRE_BYTE) begin
         return IOD_ACC_RW;
      end else begin
         return IOD_ACC_NONE;
      end
   endfunction : iod_access

   // Forms the port address of an instruction.
   function automatic logic [7:0] iod_target(input iod_op_t op, input logic [7:0] a,
                                             input logic [7:0] x);
      logic [7:0] sum;
      sum = a + x;
      if (op == IOD_IO_WRITE_INDEXED_INSTR) begin
         return sum;
      end else begin
         return a;
      end
   endfunction : iod_target

   logic [7:0] regs [0:63];
   logic [7:0] tgt;
   iod_access_t acc_cls;
   logic is_rd;
   logic is_wr;
   logic rd_ok;
   logic wr_ok;
   logic tmr_lo_rd;
   logic [7:0] next_rd_data;
   logic [11:0] tmr_count;
   logic [3:0] tmr_hi_latched;

   assign tgt = iod_target(io_op_i, io_addr_i, index_x_i);
   assign acc_cls = iod_access(tgt);

   // Splits requests into reads and writes.
   assign is_rd = io_req_i && (io_op_i == IOD_IO_READ_INSTR);
   assign is_wr = io_req_i && ((io_op_i == IOD_IO_WRITE_DIRECT_INSTR) ||
                               (io_op_i == IOD_IO_WRITE_INDEXED_INSTR));

   assign rd_ok = is_rd && ((acc_cls == IOD_ACC_RW) || (acc_cls == IOD_ACC_RO) ||
                            (acc_cls == IOD_ACC_RC));
   assign wr_ok = is_wr && ((acc_cls == IOD_ACC_RW) || (acc_cls == IOD_ACC_WO));

   assign tmr_lo_rd = rd_ok && (tgt == `IOD_A_TIMER_LOW_BYTE);

   iod_timer u_timer (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .lo_rd_i(tmr_lo_rd),
      .count_o(tmr_count),
      .hi_latched_o(tmr_hi_latched)
   );

   always_comb begin
      next_rd_data = `IOD_RST_BYTE;
      if (!rd_ok) begin
         next_rd_data = `IOD_RST_BYTE;
      end else if (tgt == `IOD_A_PENDING_VECTOR) begin
         next_rd_data = vector_i;
      end else if (tgt == `IOD_A_TIMER_LOW_BYTE) begin
         next_rd_data = tmr_count[7:0];
      end else if (tgt == `IOD_A_TIMER_HIGH_NIBBLE) begin
         next_rd_data = {4'h0, tmr_hi_latched};
      end else begin
         next_rd_data = regs[tgt[5:0]];
      end
   end

   // Registers the read answer one cycle after the request.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rd_valid_o <= 1'b0;
         rd_data_o <= `IOD_RST_BYTE;
      end else begin
         rd_valid_o <= is_rd;
         if (is_rd) begin
            rd_data_o <= next_rd_data;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         for (int i = 0; i < 64; i++) begin
            regs[i] <= `IOD_RST_BYTE;
         end
      end else if (wr_ok) begin
         regs[tgt[5:0]] <= acc_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         wr_stb_o <= 1'b0;
         wr_addr_o <= `IOD_RST_BYTE;
         wr_data_o <= `IOD_RST_BYTE;
      end else begin
         wr_stb_o <= wr_ok;
         if (wr_ok) begin
            wr_addr_o <= tgt;
            wr_data_o <= acc_i;
         end
      end
   end

   // Flags requests that hit no register of the right direction.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         unmapped_o <= 1'b0;
      end else begin
         unmapped_o <= (is_rd && !rd_ok) || (is_wr && !wr_ok);
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         vector_clr_o <= 1'b0;
      end else begin
         vector_clr_o <= rd_ok && (tgt == `IOD_A_PENDING_VECTOR);
      end
   end

   // Any write to the kick register restarts the watchdog.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         watchdog_kick_o <= 1'b0;
      end else begin
         watchdog_kick_o <= wr_ok && (tgt == `IOD_A_WATCHDOG_KICK);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   // A write followed at once by a read of the same register.
   sequence s_write_then_read;
      wr_ok && (acc_cls == IOD_ACC_RW) ##1 (rd_ok && (tgt == $past(tgt)));
   endsequence

   // A read of the timer low byte followed later by the upper register.
   sequence s_lo_then_hi;
      tmr_lo_rd ##1 !tmr_lo_rd ##1 (rd_ok && (tgt == `IOD_A_TIMER_HIGH_NIBBLE));
   endsequence

   a_read_answer: assert property (is_rd |=> rd_valid_o)
      else $error("read not answered in the next cycle");
   a_write_readback: assert property (s_write_then_read |=> rd_data_o == $past(acc_i, 2))
      else $error("readback differs from written accumulator");
   a_direct_addr: assert property (
      wr_ok && (io_op_i == IOD_IO_WRITE_DIRECT_INSTR) |=>
         wr_stb_o && (wr_addr_o == $past(io_addr_i)))
      else $error("direct write went to a wrong address");
   a_indexed_sum: assert property (
      wr_ok && (io_op_i == IOD_IO_WRITE_INDEXED_INSTR) |=>
         wr_addr_o == 8'($past(io_addr_i) + $past(index_x_i)))
      else $error("indexed write address is not base plus index");
   a_indexed_zero: assert property (
      wr_ok && (io_op_i == IOD_IO_WRITE_INDEXED_INSTR) && (io_addr_i == 8'h00) |=>
         wr_addr_o == $past(index_x_i))
      else $error("zero based indexed write ignored the index");
   a_mask_wo: assert property (
      is_rd && (tgt >= 8'h04) && (tgt <= 8'h07) |=>
         unmapped_o && (rd_data_o == 8'h00))
      else $error("pin interrupt mask answered a read");
   a_vector_clear: assert property (
      is_rd && (tgt == 8'h23) |=> vector_clr_o && (rd_data_o == $past(vector_i)))
      else $error("vector read did not return and clear");
   a_timer_ro: assert property (
      is_wr && ((tgt == 8'h24) || (tgt == 8'h25)) |=> !wr_stb_o && unmapped_o)
      else $error("timer register accepted a write");
   a_timer_lo: assert property (
      is_rd && (tgt == 8'h24) |=> rd_data_o == $past(tmr_count[7:0]))
      else $error("timer low byte read wrong");
   a_hi_from_latch: assert property (
      s_lo_then_hi |=> rd_data_o == {4'h0, $past(tmr_count[11:8], 3)})
      else $error("upper timer read not from latch");
   a_upstream_rw: assert property (
      wr_ok && (tgt == 8'h1F) |=> wr_stb_o && (wr_addr_o == 8'h1F))
      else $error("upstream control write lost");
   a_endpoint_rw: assert property (
      is_wr && (tgt >= 8'h11) && (tgt <= 8'h16) |=> wr_stb_o && !unmapped_o)
      else $error("endpoint register write refused");
   a_strobe_writable: assert property (
      wr_stb_o |-> (iod_access(wr_addr_o) == IOD_ACC_RW) ||
                   (iod_access(wr_addr_o) == IOD_ACC_WO))
      else $error("write strobe to a non writable register");

   // Refused requests answer with a flag and no side effect.
   a_read_refused: assert property (
      is_rd && !rd_ok |=> rd_valid_o && unmapped_o && (rd_data_o == 8'h00))
      else $error("refused read did not answer zero with the flag");
   a_write_refused: assert property (
      is_wr && !wr_ok |=> !wr_stb_o && !watchdog_kick_o && unmapped_o)
      else $error("refused write produced a strobe");
   a_kick_strobe: assert property (
      wr_ok && (tgt == 8'h26) |=> watchdog_kick_o && wr_stb_o)
      else $error("watchdog kick write lost");
   a_mask_strobe: assert property (
      is_wr && (tgt >= 8'h04) && (tgt <= 8'h07) |=> wr_stb_o && !unmapped_o)
      else $error("pin interrupt mask write refused");

   // The read answer is a single pulse and its data holds between reads.
   a_read_pulse: assert property (!is_rd |=> !rd_valid_o)
      else $error("read answer without a read");
   a_read_hold: assert property (!is_rd |=> $stable(rd_data_o))
      else $error("read data changed without a read");
   a_write_data: assert property (wr_ok |=> wr_data_o == $past(acc_i))
      else $error("written data differs from the accumulator");
   a_vector_only: assert property (!(is_rd && (tgt == 8'h23)) |=> !vector_clr_o)
      else $error("vector cleared without a vector read");
   a_upstream_read: assert property (
      is_rd && (tgt == 8'h1F) |=> rd_valid_o && !unmapped_o)
      else $error("upstream control read refused");
   a_endpoint_read: assert property (
      is_rd && (tgt >= 8'h11) && (tgt <= 8'h16) |=> rd_valid_o && !unmapped_o)
      else $error("endpoint register read refused");
   a_hi_read: assert property (
      is_rd && (tgt == 8'h25) |=> rd_data_o == {4'h0, $past(tmr_hi_latched)})
      else $error("upper timer register not read from the latch");

endmodule : iod_decode

// ===== verif/iod_cpu_model.sv
`timescale 1ns/1ns

module iod_cpu_model (
   // Clock.
   input wire logic clk_i,
   // Instruction towards the decoder.
   output logic io_req_o,
   output iod_pkg::iod_op_t io_op_o,
   output logic [7:0] io_addr_o,
   output logic [7:0] index_x_o,
   output logic [7:0] acc_o,
   // Answers from the decoder.
   input wire logic rd_valid_i,
   input wire logic [7:0] rd_data_i,
   input wire logic unmapped_i,
   input wire logic wr_stb_i,
   input wire logic [7:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic watchdog_kick_i,
   input wire logic vector_clr_i
);
   import iod_pkg::*;

   // Answer seen in the cycle after the request is taken.
   logic rvalid, unm, wstb, kick, vclr;
   logic [7:0] rdata, waddr, wdata;

   // Bus starts idle.
   initial begin
      io_req_o = 1'b0;
      io_op_o = IOD_IO_NO_INSTR;
      io_addr_o = 8'h00;
      index_x_o = 8'h00;
      acc_o = 8'h00;
   end

   // Tells whether an address holds a documented register.
   function automatic bit known(input logic [7:0] a);
      return a <= 8'h09 || (a >= 8'h10 && a <= 8'h16) || a == 8'h1F ||
         (a >= 8'h20 && a <= 8'h29 && a != 8'h22 && a != 8'h27);
   endfunction : known

   // One instruction, called at a falling edge; returns at a falling edge.
   task automatic issue(input iod_op_t op, input logic [7:0] a, input logic [7:0] x,
                        input logic [7:0] d, input bit keep);
      if (op != IOD_IO_READ_INSTR &&
          !known(a + (op == IOD_IO_WRITE_INDEXED_INSTR ? x : 8'h00))) begin
         return;
      end
      io_req_o = 1'b1;
      io_op_o = op;
      io_addr_o = a;
      index_x_o = x;
      acc_o = d;
      @(negedge clk_i);
      rvalid = rd_valid_i;
      rdata = rd_data_i;
      unm = unmapped_i;
      wstb = wr_stb_i;
      waddr = wr_addr_i;
      wdata = wr_data_i;
      kick = watchdog_kick_i;
      vclr = vector_clr_i;
      if (!keep) begin
         // Request and op lines go idle; address, index and data lines show the inverse of the last value.
         io_req_o = 1'b0;
         io_op_o = IOD_IO_NO_INSTR;
         io_addr_o = ~io_addr_o;
         index_x_o = ~index_x_o;
         acc_o = ~acc_o;
         @(negedge clk_i);
      end
   endtask : issue
endmodule : iod_cpu_model

// ===== verif/iod_tb.sv
`timescale 1ns/1ns
`include "iod_map.svh"

module tb;
   import iod_pkg::*;

   logic clk_i, srst_i, io_req_i, rd_valid_o, unmapped_o, wr_stb_o, watchdog_kick_o, vector_clr_o;
   iod_op_t io_op_i;
   logic [7:0] io_addr_i, index_x_i, acc_i, vector_i, rd_data_o, wr_addr_o, wr_data_o;
   int errors, n_tests;

   iod_decode i_dut (.clk_i(clk_i), .srst_i(srst_i), .io_req_i(io_req_i), .io_op_i(io_op_i),
      .io_addr_i(io_addr_i), .index_x_i(index_x_i), .acc_i(acc_i), .rd_valid_o(rd_valid_o),
      .rd_data_o(rd_data_o), .unmapped_o(unmapped_o), .wr_stb_o(wr_stb_o),
      .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .watchdog_kick_o(watchdog_kick_o),
      .vector_i(vector_i), .vector_clr_o(vector_clr_o));

   iod_cpu_model i_cpu (.clk_i(clk_i), .io_req_o(io_req_i), .io_op_o(io_op_i),
      .io_addr_o(io_addr_i), .index_x_o(index_x_i), .acc_o(acc_i), .rd_valid_i(rd_valid_o),
      .rd_data_i(rd_data_o), .unmapped_i(unmapped_o), .wr_stb_i(wr_stb_o),
      .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o), .watchdog_kick_i(watchdog_kick_o),
      .vector_clr_i(vector_clr_o));

   // Free-running clock.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Byte and flag comparisons.
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask : chk1

   task automatic rd(input logic [7:0] a);
      i_cpu.issue(IOD_IO_READ_INSTR, a, 8'h00, 8'h00, 1'b0);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit keep);
      i_cpu.issue(IOD_IO_WRITE_DIRECT_INSTR, a, 8'h00, d, keep);
   endtask : wr

   // Back-to-back writes to every read/write register, then read back.
   task automatic test_rw();
      logic [7:0] tbl[18] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09, 8'h10, 8'h11, 8'h12,
         8'h13, 8'h14, 8'h15, 8'h16, 8'h1F, 8'h20, 8'h21, 8'h28, 8'h29};
      rd(`IOD_A_UPSTREAM_TRAFFIC_CTRL);
      chk8(i_cpu.rdata, `IOD_RST_BYTE);
      foreach (tbl[i]) begin
         wr(tbl[i], tbl[i] ^ 8'hC3, i != 17);
         chk1(i_cpu.wstb, 1'b1);
         chk8(i_cpu.waddr, tbl[i]);
         chk8(i_cpu.wdata, tbl[i] ^ 8'hC3);
      end
      foreach (tbl[i]) begin
         rd(tbl[i]);
         chk1(i_cpu.rvalid & ~i_cpu.unm, 1'b1);
         chk8(i_cpu.rdata, tbl[i] ^ 8'hC3);
      end
      $display("test rw done");
   endtask : test_rw

   // Indexed writes, including a zero base and a wrapping sum, each read back at once.
   task automatic test_index();
      logic [7:0] base[3] = '{8'h10, 8'h00, 8'hF0};
      logic [7:0] x[3] = '{8'h03, 8'h1F, 8'h21};
      foreach (base[i]) begin
         i_cpu.issue(IOD_IO_WRITE_INDEXED_INSTR, base[i], x[i], 8'h70 + 8'(i), 1'b1);
         chk8(i_cpu.waddr, base[i] + x[i]);
         rd(base[i] + x[i]);
         chk8(i_cpu.rdata, 8'h70 + 8'(i));
      end
      $display("test index done");
   endtask : test_index

   // Write-only registers take strobes but read as refused.
   task automatic test_wo();
      logic [7:0] tbl[5] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h26};
      foreach (tbl[i]) begin
         wr(tbl[i], 8'h5A, 1'b0);
         chk1(i_cpu.wstb & ~i_cpu.unm, 1'b1);
         chk1(i_cpu.kick, tbl[i] == `IOD_A_WATCHDOG_KICK);
         rd(tbl[i]);
         chk1(i_cpu.rvalid & i_cpu.unm, 1'b1);
         chk8(i_cpu.rdata, 8'h00);
      end
      $display("test wo done");
   endtask : test_wo

   // Vector read clears it; read-only and undefined places are refused.
   task automatic test_ro();
      logic [7:0] tbl[3] = '{8'h23, 8'h24, 8'h25};
      vector_i = 8'h5A;
      rd(`IOD_A_PENDING_VECTOR);
      chk8(i_cpu.rdata, 8'h5A);
      chk1(i_cpu.vclr, 1'b1);
      foreach (tbl[i]) begin
         wr(tbl[i], 8'hFF, 1'b0);
         chk1(i_cpu.wstb | i_cpu.vclr, 1'b0);
         chk1(i_cpu.unm, 1'b1);
      end
      rd(8'h0A);
      chk1(i_cpu.unm, 1'b1);
      chk8(i_cpu.rdata, 8'h00);
      $display("test ro done");
   endtask : test_ro

   // Tick rate and latching of the upper timer bits.
   task automatic test_timer();
      logic [7:0] la, lb;
      logic [3:0] h0;
      logic [11:0] e;
      rd(`IOD_A_TIMER_LOW_BYTE);
      la = i_cpu.rdata;
      repeat (298) @(negedge clk_i);
      rd(`IOD_A_TIMER_LOW_BYTE);
      chk8(i_cpu.rdata - la, 8'h03);
      la = i_cpu.rdata;
      rd(`IOD_A_TIMER_HIGH_NIBBLE);
      h0 = i_cpu.rdata[3:0];
      chk8(i_cpu.rdata & 8'hF0, 8'h00);
      repeat (25700) @(negedge clk_i);
      rd(`IOD_A_TIMER_HIGH_NIBBLE);
      chk8(i_cpu.rdata, {4'h0, h0});
      rd(`IOD_A_TIMER_LOW_BYTE);
      lb = i_cpu.rdata;
      rd(`IOD_A_TIMER_HIGH_NIBBLE);
      e = {h0, la} + 12'h100 + {4'h0, lb - la};
      chk8(i_cpu.rdata, {4'h0, e[11:8]});
      $display("test timer done");
   endtask : test_timer

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   // Cuts a hang short.
   initial begin
      #900000;
      errors++;
      stop_test();
   end

   // Main sequence.
   initial begin
      errors = 0;
      n_tests = 0;
      srst_i = 1'b1;
      vector_i = 8'h00;
      repeat (2) @(negedge clk_i);
      srst_i = 1'b0;
      test_rw();
      test_index();
      test_wo();
      test_ro();
      test_timer();
      stop_test();
   end
endmodule : tb
